// ===== common/ras_pkg.sv
// constants and carrier types for the rtc alarm and square-wave control block
package ras_pkg;

  // register addresses
  localparam logic [4:0] ALM_BASE_ADDR = 5'h07;
  localparam logic [4:0] ALM_LAST_ADDR = 5'h0D;
  localparam logic [4:0] CTRL_ADDR     = 5'h0E;
  localparam logic [4:0] STAT_ADDR     = 5'h0F;

  // byte indices inside the alarm register bank
  localparam int A1_SEC_IDX  = 0;
  localparam int A1_MIN_IDX  = 1;
  localparam int A1_HOUR_IDX = 2;
  localparam int A1_DD_IDX   = 3;
  localparam int A2_MIN_IDX  = 4;
  localparam int A2_HOUR_IDX = 5;
  localparam int A2_DD_IDX   = 6;
  localparam int ALM_BYTES   = 7;

  // field positions inside alarm bytes
  localparam int MASK_BIT = 7;
  localparam int DYDT_BIT = 6;

  // reset values
  localparam logic [7:0] CTRL_RESET  = 8'h98;
  localparam logic [1:0] FLAG_RESET  = 2'h0;
  localparam logic [7:0] ALARM_RESET = 8'h00;
  localparam logic [6:0] A2_SEC_ZERO = 7'h00;

  // input-select codes
  localparam logic [1:0] SEL_32768 = 2'h0;
  localparam logic [1:0] SEL_8192  = 2'h1;
  localparam logic [1:0] SEL_60    = 2'h2;
  localparam logic [1:0] SEL_50    = 2'h3;

  // rate-select codes
  localparam logic [1:0] RATE_1HZ  = 2'h0;
  localparam logic [1:0] RATE_1K   = 2'h1;
  localparam logic [1:0] RATE_4K   = 2'h2;
  localparam logic [1:0] RATE_8K   = 2'h3;

  // input and output frequencies in Hz
  localparam int IN_HZ_32768  = 32768;
  localparam int IN_HZ_8192   = 8192;
  localparam int IN_HZ_60     = 60;
  localparam int IN_HZ_50     = 50;
  localparam int WAVE_HZ_1024 = 1024;
  localparam int WAVE_HZ_4096 = 4096;
  localparam int WAVE_HZ_8192 = 8192;

  // divider terminal counts and fast-wave counter taps
  localparam logic [14:0] TERM_32768 = 15'(IN_HZ_32768 - 1);
  localparam logic [14:0] TERM_8192  = 15'(IN_HZ_8192 - 1);
  localparam logic [14:0] TERM_60    = 15'(IN_HZ_60 - 1);
  localparam logic [14:0] TERM_50    = 15'(IN_HZ_50 - 1);
  localparam int TAP_1K = $clog2(IN_HZ_32768 / WAVE_HZ_1024) - 1;
  localparam int TAP_4K = $clog2(IN_HZ_32768 / WAVE_HZ_4096) - 1;
  localparam int TAP_8K = $clog2(IN_HZ_32768 / WAVE_HZ_8192) - 1;

  typedef struct packed {
    logic count_enable;
    logic input_rate_sel_hi;
    logic input_rate_sel_lo;
    logic wave_rate_hi;
    logic wave_rate_lo;
    logic irq_mode_select;
    logic alarm_two_irq_en;
    logic alarm_one_irq_en;
  } ras_ctrl_t;

  typedef struct packed {
    logic [6:0] sec;
    logic [6:0] min;
    logic [6:0] hour;
    logic [2:0] day;
    logic [5:0] date;
  } ras_time_t;

  typedef struct packed {
    logic [3:0] mask;
    logic       weekday_not_date;
    logic [6:0] sec;
    logic [6:0] min;
    logic [6:0] hour;
    logic [5:0] daydate;
  } ras_alarm_t;

  typedef struct packed {
    logic       wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } ras_reg_req_t;

endpackage : ras_pkg

// ===== hw/ras_alarm_match.sv
// mask-decoded compare of one alarm setting against the current time
module ras_alarm_match (
  input  ras_pkg::ras_alarm_t alarm,
  input  ras_pkg::ras_time_t  now,
  output logic                match
);

  logic eq_sec;
  logic eq_min;
  logic eq_hour;
  logic eq_dd;

  assign eq_sec  = (now.sec == alarm.sec);
  assign eq_min  = (now.min == alarm.min);
  assign eq_hour = (now.hour == alarm.hour);

  assign eq_dd = alarm.weekday_not_date ?
                 ({3'h0, now.day} == alarm.daydate) :
                 (now.date == alarm.daydate);

  assign match = (alarm.mask[0] | eq_sec) &
                 (alarm.mask[1] | eq_min) &
                 (alarm.mask[2] | eq_hour) &
                 (alarm.mask[3] | eq_dd);

endmodule : ras_alarm_match

// ===== hw/ras_control.sv
// control, alarm flags, divider and shared output of the rtc
module ras_control (
  input  logic                  sys_clk,
  input  logic                  nrst,
  input  logic                  ext_clk_pin,
  input  ras_pkg::ras_reg_req_t reg_req,
  output logic [7:0]            reg_rdata,
  input  ras_pkg::ras_time_t    time_now,
  input  logic                  time_update,
  input  logic                  chain_clear,
  output logic                  sec_tick,
  output logic                  wave_or_irq_out
);

  typedef struct packed {
    ras_pkg::ras_ctrl_t ctrl;
    logic [1:0]         flags;
    logic [6:0][7:0]    alm;
    logic [1:0]         clk_sync;
    logic               clk_prev;
    logic [14:0]        cnt;
    logic               tick;
    logic               wave_pin;
    logic [7:0]         rdata;
  } ras_state_t;

  ras_state_t               st_reg;
  ras_state_t               st_next;
  ras_pkg::ras_alarm_t [1:0] alarm_set;
  logic [1:0]               match;
  logic                     rise;
  logic [14:0]              term;
  logic [14:0]              half;
  logic                     square;
  logic                     irq_active;
  logic [1:0]               input_sel;
  logic [1:0]               rate_sel;
  logic                     alm_hit;
  logic [2:0]               alm_idx;
  logic                     wr_stat;

  assign input_sel = {st_reg.ctrl.input_rate_sel_hi,
                      st_reg.ctrl.input_rate_sel_lo};
  assign rate_sel  = {st_reg.ctrl.wave_rate_hi, st_reg.ctrl.wave_rate_lo};
  assign rise      = st_reg.clk_sync[1] & ~st_reg.clk_prev;
  assign alm_hit   = (reg_req.addr >= ras_pkg::ALM_BASE_ADDR) &&
                     (reg_req.addr <= ras_pkg::ALM_LAST_ADDR);
  assign alm_idx   = 3'(reg_req.addr - ras_pkg::ALM_BASE_ADDR);
  assign wr_stat   = reg_req.wr && (reg_req.addr == ras_pkg::STAT_ADDR);

  // alarm settings unpacked from the register bank
  always_comb begin
    alarm_set[0].mask = {st_reg.alm[ras_pkg::A1_DD_IDX][ras_pkg::MASK_BIT],
                         st_reg.alm[ras_pkg::A1_HOUR_IDX][ras_pkg::MASK_BIT],
                         st_reg.alm[ras_pkg::A1_MIN_IDX][ras_pkg::MASK_BIT],
                         st_reg.alm[ras_pkg::A1_SEC_IDX][ras_pkg::MASK_BIT]};
    alarm_set[0].weekday_not_date =
      st_reg.alm[ras_pkg::A1_DD_IDX][ras_pkg::DYDT_BIT];
    alarm_set[0].sec     = st_reg.alm[ras_pkg::A1_SEC_IDX][6:0];
    alarm_set[0].min     = st_reg.alm[ras_pkg::A1_MIN_IDX][6:0];
    alarm_set[0].hour    = st_reg.alm[ras_pkg::A1_HOUR_IDX][6:0];
    alarm_set[0].daydate = st_reg.alm[ras_pkg::A1_DD_IDX][5:0];
    // second alarm always needs seconds at zero
    alarm_set[1].mask = {st_reg.alm[ras_pkg::A2_DD_IDX][ras_pkg::MASK_BIT],
                         st_reg.alm[ras_pkg::A2_HOUR_IDX][ras_pkg::MASK_BIT],
                         st_reg.alm[ras_pkg::A2_MIN_IDX][ras_pkg::MASK_BIT],
                         1'b0};
    alarm_set[1].weekday_not_date =
      st_reg.alm[ras_pkg::A2_DD_IDX][ras_pkg::DYDT_BIT];
    alarm_set[1].sec     = ras_pkg::A2_SEC_ZERO;
    alarm_set[1].min     = st_reg.alm[ras_pkg::A2_MIN_IDX][6:0];
    alarm_set[1].hour    = st_reg.alm[ras_pkg::A2_HOUR_IDX][6:0];
    alarm_set[1].daydate = st_reg.alm[ras_pkg::A2_DD_IDX][5:0];
  end

  generate
    for (genvar i = 0; i < 2; i++) begin : g_alarm
      ras_alarm_match u_match (
        .alarm (alarm_set[i]),
        .now   (time_now),
        .match (match[i])
      );
    end
  endgenerate

  always_comb begin
    unique case (input_sel)
      ras_pkg::SEL_32768: term = ras_pkg::TERM_32768;
      ras_pkg::SEL_8192:  term = ras_pkg::TERM_8192;
      ras_pkg::SEL_60:    term = ras_pkg::TERM_60;
      ras_pkg::SEL_50:    term = ras_pkg::TERM_50;
    endcase
  end

  assign half = term >> 1;

  // wave source, rate bits only at 32768 input
  always_comb begin
    square = (st_reg.cnt <= half);
    if (input_sel == ras_pkg::SEL_32768) begin
      unique case (rate_sel)
        ras_pkg::RATE_1HZ: square = (st_reg.cnt <= half);
        ras_pkg::RATE_1K:  square = st_reg.cnt[ras_pkg::TAP_1K];
        ras_pkg::RATE_4K:  square = st_reg.cnt[ras_pkg::TAP_4K];
        ras_pkg::RATE_8K:  square = st_reg.cnt[ras_pkg::TAP_8K];
      endcase
    end
  end

  // flag gated by its enable and irq mode
  assign irq_active = st_reg.ctrl.irq_mode_select &
                      ((st_reg.flags[0] & st_reg.ctrl.alarm_one_irq_en) |
                       (st_reg.flags[1] & st_reg.ctrl.alarm_two_irq_en));

  always_comb begin
    st_next = st_reg;
    st_next.clk_sync = {st_reg.clk_sync[0], ext_clk_pin};
    st_next.clk_prev = st_reg.clk_sync[1];
    st_next.tick     = 1'b0;

    // divider held at zero while disabled
    if (!st_reg.ctrl.count_enable || chain_clear) begin
      st_next.cnt = 15'h0000;
    end else if (rise) begin
      if (st_reg.cnt >= term) begin
        // a ratio change mid-count wraps without a short second tick
        st_next.cnt  = 15'h0000;
        st_next.tick = (st_reg.cnt == term);
      end else begin
        st_next.cnt = st_reg.cnt + 15'h0001;
      end
    end

    if (reg_req.wr && reg_req.addr == ras_pkg::CTRL_ADDR) begin
      st_next.ctrl = ras_pkg::ras_ctrl_t'(reg_req.wdata);
    end
    if (reg_req.wr && alm_hit) begin
      st_next.alm[alm_idx] = reg_req.wdata;
    end

    // set on update beats a written zero
    for (int i = 0; i < 2; i++) begin
      if (wr_stat && !reg_req.wdata[i]) begin
        st_next.flags[i] = 1'b0;
      end
      if (time_update && match[i]) begin
        st_next.flags[i] = 1'b1;
      end
    end

    // irq mode replaces the wave, interrupt drives low
    st_next.wave_pin = st_reg.ctrl.irq_mode_select ? ~irq_active : square;

    if (reg_req.addr == ras_pkg::CTRL_ADDR) begin
      st_next.rdata = st_reg.ctrl;
    end else if (reg_req.addr == ras_pkg::STAT_ADDR) begin
      st_next.rdata = {6'h00, st_reg.flags};
    end else if (alm_hit) begin
      st_next.rdata = st_reg.alm[alm_idx];
    end else begin
      st_next.rdata = 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg.ctrl     <= ras_pkg::ras_ctrl_t'(ras_pkg::CTRL_RESET);
      st_reg.flags    <= ras_pkg::FLAG_RESET;
      st_reg.alm      <= {ras_pkg::ALM_BYTES{ras_pkg::ALARM_RESET}};
      st_reg.clk_sync <= 2'h0;
      st_reg.clk_prev <= 1'b0;
      st_reg.cnt      <= 15'h0000;
      st_reg.tick     <= 1'b0;
      st_reg.wave_pin <= 1'b1;
      st_reg.rdata    <= 8'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata       = st_reg.rdata;
  assign sec_tick        = st_reg.tick;
  assign wave_or_irq_out = st_reg.wave_pin;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence a1_update_s;
    time_update && !(wr_stat && !reg_req.wdata[0]);
  endsequence

  sequence a2_update_s;
    time_update && !(wr_stat && !reg_req.wdata[1]);
  endsequence

  sequence enable_rise_s;
    st_reg.ctrl.count_enable && !chain_clear && rise && st_reg.cnt == 15'h0000;
  endsequence

  sec_every_a: assert property (
    a1_update_s ##0 (alarm_set[0].mask == 4'hF) |=> st_reg.flags[0])
    else $error("first alarm missed once-per-second match");

  sec_only_a: assert property (
    a1_update_s ##0 (alarm_set[0].mask == 4'hE &&
     time_now.sec != alarm_set[0].sec && !st_reg.flags[0])
     |=> !st_reg.flags[0])
    else $error("first alarm fired on wrong seconds");

  min_sec_a: assert property (
    a1_update_s ##0 (alarm_set[0].mask == 4'hC &&
     time_now.sec == alarm_set[0].sec &&
     time_now.min == alarm_set[0].min) |=> st_reg.flags[0])
    else $error("first alarm missed minute and second match");

  date_full_a: assert property (
    a1_update_s ##0 (alarm_set[0].mask == 4'h0 &&
     !alarm_set[0].weekday_not_date &&
     time_now.date != alarm_set[0].daydate && !st_reg.flags[0])
     |=> !st_reg.flags[0])
    else $error("first alarm ignored date");

  minute_rate_a: assert property (
    a2_update_s ##0 (alarm_set[1].mask == 4'hE &&
     time_now.sec == 7'h00) |=> st_reg.flags[1])
    else $error("second alarm missed second zero");

  hour_min_a: assert property (
    a2_update_s ##0 (alarm_set[1].mask == 4'h8 &&
     time_now.hour != alarm_set[1].hour && !st_reg.flags[1])
     |=> !st_reg.flags[1])
    else $error("second alarm ignored hours");

  weekday_two_a: assert property (
    a2_update_s ##0 (alarm_set[1].mask == 4'h0 &&
     alarm_set[1].weekday_not_date &&
     {3'h0, time_now.day} != alarm_set[1].daydate && !st_reg.flags[1])
     |=> !st_reg.flags[1])
    else $error("second alarm ignored weekday");

  chain_hold_a: assert property (
    !st_reg.ctrl.count_enable |=> st_reg.cnt == 15'h0000 && !st_reg.tick)
    else $error("divider advanced while disabled");

  restart_count_a: assert property (
    enable_rise_s |=> st_reg.cnt == 15'h0001)
    else $error("divider did not restart on first input edge");

  tick_ratio_a: assert property (
    st_reg.tick |-> $past(st_reg.cnt) == $past(term))
    else $error("second tick at wrong divider count");

  fast_wave_a: assert property (
    !st_reg.ctrl.irq_mode_select && input_sel == ras_pkg::SEL_32768 &&
    rate_sel == ras_pkg::RATE_8K |=>
    wave_or_irq_out == $past(st_reg.cnt[ras_pkg::TAP_8K]))
    else $error("fast wave not on counter tap");

  slow_wave_a: assert property (
    !st_reg.ctrl.irq_mode_select && input_sel != ras_pkg::SEL_32768 |=>
    wave_or_irq_out == $past(st_reg.cnt <= half))
    else $error("non-32768 input must give 1Hz wave");

  irq_pin_a: assert property (
    st_reg.ctrl.irq_mode_select &&
    !(st_reg.flags[0] && st_reg.ctrl.alarm_one_irq_en) &&
    !(st_reg.flags[1] && st_reg.ctrl.alarm_two_irq_en) |=> wave_or_irq_out)
    else $error("interrupt driven without enabled flag");

  flag_set_a: assert property (
    time_update && match[1] && !st_reg.ctrl.alarm_two_irq_en
    |=> st_reg.flags[1])
    else $error("flag not set with interrupt disabled");

  flag_sticky_a: assert property (
    st_reg.flags[0] && !(wr_stat && !reg_req.wdata[0]) |=> st_reg.flags[0])
    else $error("first alarm flag lost without a written zero");

  stat_zero_a: assert property (
    reg_req.addr == ras_pkg::STAT_ADDR |=> reg_rdata[7:2] == 6'h00)
    else $error("status upper bits not zero");

endmodule : ras_control

// ===== testbench/ras_clk_src.sv
// external time-base source that counts its own rising edges
module ras_clk_src (
  input  logic        sys_clk,
  output logic        ext_clk_pin,
  output logic [31:0] edge_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph;
  initial begin
    ph = 3'h0;
    ext_clk_pin = 1'b0;
    edge_cnt = 32'h0;
  end
  // four cycles high, four low: well inside the synchroniser limit
  always @(negedge sys_clk) begin
    ph <= ph + 3'h1;
    if (ph == 3'h3) begin
      ext_clk_pin <= 1'b1;
      edge_cnt    <= edge_cnt + 32'h1;
    end
    if (ph == 3'h7) begin
      ext_clk_pin <= 1'b0;
    end
  end
endmodule : ras_clk_src

// ===== testbench/rtc_alarm_squarewave_control_bench.sv
// self-checking bench for the rtc control, alarm and wave block
module rtc_alarm_squarewave_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] CA = ras_pkg::CTRL_ADDR;
  localparam logic [4:0] SA = ras_pkg::STAT_ADDR;
  localparam ras_pkg::ras_time_t T  = {7'h30, 7'h15, 7'h10, 3'h3, 6'h21};
  localparam ras_pkg::ras_time_t T0 = {7'h00, 7'h15, 7'h10, 3'h3, 6'h21};
  localparam logic [31:0] A1N = 32'h31151021;
  localparam logic [23:0] A2N = 24'h592301;
  logic                  sys_clk = 1'b0;
  logic                  nrst = 1'b0;
  logic                  ext_clk_pin;
  ras_pkg::ras_reg_req_t reg_req;
  logic [7:0]            reg_rdata;
  ras_pkg::ras_time_t    time_now;
  logic                  time_update;
  logic                  chain_clear;
  logic                  sec_tick;
  logic                  wave_or_irq_out;
  logic [31:0]           edge_cnt;
  int                    err_total = 0;
  int                    tests_run = 0;
  int                    cyc = 0;

  always #4 sys_clk = ~sys_clk;

  ras_control dut_u (
    .sys_clk         (sys_clk),
    .nrst            (nrst),
    .ext_clk_pin     (ext_clk_pin),
    .reg_req         (reg_req),
    .reg_rdata       (reg_rdata),
    .time_now        (time_now),
    .time_update     (time_update),
    .chain_clear     (chain_clear),
    .sec_tick        (sec_tick),
    .wave_or_irq_out (wave_or_irq_out)
  );

  ras_clk_src src_u (
    .sys_clk     (sys_clk),
    .ext_clk_pin (ext_clk_pin),
    .edge_cnt    (edge_cnt)
  );

  task print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  // a hung wait ends the run as a failure
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      print_verdict;
    end
  end

  task check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_req <= '{wr: 1'b1, addr: a, wdata: d};
    @(negedge sys_clk);
    reg_req.wr <= 1'b0;
  endtask : wr

  task rchk(input logic [4:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    reg_req.addr <= a;
    @(negedge sys_clk);
    check(reg_rdata, e);
  endtask : rchk

  // load control and alarms, clear flags, then one update pulse
  task do_alarm(input logic [7:0] c, input logic [55:0] al,
                input ras_pkg::ras_time_t t, input logic [1:0] e);
    wr(CA, c);
    for (int i = 0; i < ras_pkg::ALM_BYTES; i++) begin
      wr(ras_pkg::ALM_BASE_ADDR + 5'(i), al[55 - 8 * i -: 8]);
    end
    wr(SA, 8'h00);
    time_now <= t;
    rchk(SA, 8'h00);
    @(negedge sys_clk);
    time_update <= 1'b1;
    @(negedge sys_clk);
    time_update <= 1'b0;
    rchk(SA, {6'h00, e});
    if (c[2]) begin
      check(wave_or_irq_out, !(|(e & c[1:0])));
    end
  endtask : do_alarm

  // count wave rises over 64 input edges; e of 0 means fewer than 2
  task wave(input logic [7:0] c, input int e);
    int          r;
    logic        p;
    logic [31:0] e0;
    wr(CA, c);
    repeat (80) @(negedge sys_clk);
    @(edge_cnt);
    #1;
    e0 = edge_cnt;
    r = 0;
    p = wave_or_irq_out;
    while (edge_cnt != e0 + 32'd64) begin
      @(negedge sys_clk);
      if (wave_or_irq_out === 1'b1 && p === 1'b0) r++;
      p = wave_or_irq_out;
    end
    check((e == 0 && r < 2) ? 16'h0 : 16'(r), 16'(e));
  endtask : wave

  // hold the chain off, then count input edges up to the first tick
  task div(input logic [1:0] s, input int n);
    int          t;
    logic [31:0] e0;
    wr(CA, {1'b0, s, 5'h18});
    t = 0;
    repeat (960) begin
      @(negedge sys_clk);
      if (sec_tick === 1'b1) t++;
    end
    check(16'(t), 16'h0);
    @(negedge ext_clk_pin);
    wr(CA, {1'b1, s, 5'h18});
    e0 = edge_cnt;
    t = 0;
    while (sec_tick !== 1'b1 && t < 8 * n + 64) begin
      @(negedge sys_clk);
      t++;
    end
    check(16'(edge_cnt - e0), 16'(n));
  endtask : div

  initial begin
    reg_req = '0;
    time_now = '0;
    time_update = 1'b0;
    chain_clear = 1'b0;
    repeat (4) @(negedge sys_clk);
    nrst <= 1'b1;
    rchk(CA, 8'h98);
    rchk(SA, 8'h00);
    wr(5'h05, 8'hFF);
    rchk(5'h05, 8'h00);
    do_alarm(8'h98, {32'h80808080, A2N}, T, 2'b01);
    do_alarm(8'h98, {32'h808080C0, A2N}, T, 2'b01);
    do_alarm(8'h98, {32'h30808080, A2N}, T, 2'b01);
    do_alarm(8'h98, {32'h31808080, A2N}, T, 2'b00);
    do_alarm(8'h98, {32'h30158080, A2N}, T, 2'b01);
    do_alarm(8'h98, {32'h30168080, A2N}, T, 2'b00);
    do_alarm(8'h98, {32'h30151080, A2N}, T, 2'b01);
    do_alarm(8'h98, {32'h30151180, A2N}, T, 2'b00);
    do_alarm(8'h98, {32'h30151021, A2N}, T, 2'b01);
    do_alarm(8'h98, {32'h30151043, A2N}, T, 2'b01);
    do_alarm(8'h98, {32'h30151003, A2N}, T, 2'b00);
    do_alarm(8'h98, {A1N, 24'h808080}, T0, 2'b10);
    do_alarm(8'h98, {A1N, 24'h808080}, T, 2'b00);
    do_alarm(8'h98, {A1N, 24'h158080}, T0, 2'b10);
    do_alarm(8'h98, {A1N, 24'h168080}, T0, 2'b00);
    do_alarm(8'h98, {A1N, 24'h151080}, T0, 2'b10);
    do_alarm(8'h98, {A1N, 24'h151180}, T0, 2'b00);
    do_alarm(8'h98, {A1N, 24'h151021}, T0, 2'b10);
    do_alarm(8'h98, {A1N, 24'h151003}, T0, 2'b00);
    do_alarm(8'h98, {A1N, 24'h151044}, T0, 2'b00);
    do_alarm(8'h98, {A1N, 24'h151043}, T0, 2'b10);
    wr(SA, 8'hFF);
    rchk(SA, 8'h02);
    wr(SA, 8'hFD);
    rchk(SA, 8'h00);
    do_alarm(8'h9D, {32'h80808080, A2N}, T, 2'b01);
    do_alarm(8'h9E, {32'h80808080, A2N}, T, 2'b01);
    do_alarm(8'h9E, {A1N, 24'h808080}, T0, 2'b10);
    do_alarm(8'h9B, {A1N, 24'h808080}, T0, 2'b10);
    rchk(CA, 8'h9B);
    wave(8'h98, 16);
    wave(8'h90, 8);
    wave(8'h88, 2);
    wave(8'h80, 0);
    wave(8'hF8, 0);
    div(2'h1, 8192);
    div(2'h2, 60);
    div(2'h3, 50);
    print_verdict;
  end
endmodule : rtc_alarm_squarewave_control_bench
